// ==== hw/adcsq_pkg.sv ====
// Package: constants and carrier types for the converter sequencer
`default_nettype none
package adcsq_pkg;
  localparam int          ADCSQ_WORD_BITS    = 16;
  localparam int          ADCSQ_DATA_BITS    = 12;
  localparam int          ADCSQ_NUM_CH       = 8;
  // Control word field positions
  localparam int          ADCSQ_POS_WRITE    = 15;
  localparam int          ADCSQ_POS_REPEAT   = 14;
  localparam int          ADCSQ_POS_CH_HI    = 13;
  localparam int          ADCSQ_POS_CH_LO    = 6;
  localparam int          ADCSQ_POS_TEMP     = 4;
  localparam int          ADCSQ_POS_EXTREF   = 2;
  localparam int          ADCSQ_POS_TAVG     = 1;
  localparam int          ADCSQ_POS_SLEEP    = 0;
  // Serial clock edge numbers
  localparam logic [4:0]  ADCSQ_TRACK_EDGE   = 5'h0e;
  localparam logic [4:0]  ADCSQ_FULL_EDGES   = 5'h10;
  // Result tags
  localparam logic [3:0]  ADCSQ_TAG_TEMP     = 4'h8;
  localparam logic [3:0]  ADCSQ_TAG_TEMP_AVG = 4'h9;
  localparam logic [15:0] ADCSQ_ALL_ONES     = 16'hffff;
  // Reset values
  localparam logic [14:0] ADCSQ_CTRL_RESET   = 15'h0000;
  // Reset pin pulse discrimination: above 100 ns is full sleep
  localparam int          ADCSQ_CLK_MHZ      = 50;
  localparam int          ADCSQ_RST_PULSE_NS = 100;
  localparam int          ADCSQ_RST_PULSE_CYC = (ADCSQ_RST_PULSE_NS * ADCSQ_CLK_MHZ) / 1000;

  typedef struct packed {
    logic       repeat_mode;
    logic [7:0] channel_select_bits;
    logic       unused_5;
    logic       temp_select;
    logic       unused_3;
    logic       external_reference_select;
    logic       temperature_average_enable;
    logic       partial_sleep_bit;
  } adcsq_ctrl_s;

  typedef struct packed {
    logic [3:0]  result_channel_tag;
    logic [11:0] data;
  } adcsq_result_s;

  typedef enum logic [1:0] {
    ADCSQ_PWR_NORMAL  = 2'b00,
    ADCSQ_PWR_PARTIAL = 2'b01,
    ADCSQ_PWR_FULL    = 2'b10
  } adcsq_pwr_e;
endpackage
`default_nettype wire

// ==== hw/adcsq_sync2.sv ====
// Two-flop synchroniser for one external level
`default_nettype none
module adcsq_sync2 (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic reset_value_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;
  logic next_stage1;
  logic next_sync;

  always_comb
  begin
    next_stage1 = async_in;
    next_sync   = stage1;
  end

  // Synchronous reset, so a data-dependent reset value is legal here
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      stage1   <= reset_value_in;
      sync_out <= reset_value_in;
    end
    else
    begin
      stage1   <= next_stage1;
      sync_out <= next_sync;
    end
  end
endmodule
`default_nettype wire

// ==== hw/adcsq_core.sv ====
// Converter sequencer: serial framing, channel sequencing and power modes
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [R01] Control word: write, repeat, channels, temp, ref, avg, sleep
// [R02] Output: 4-bit tag then 12-bit result
// [R03] Early frame end aborts, releases output, no write
// [R04] First single-pass transfer only programs; output meaningless
// [R05] Result shifts out one transfer after conversion start
// [R06] Single-pass converts each selected channel once, ascending
// [R07] All ones when nothing selected or sequence done
// [R08] Repeat wraps from highest to lowest selected channel
// [R09] Temperature converted after last analog channel each pass
// [R10] Any accepted write in repeat restarts sequence
// [R11] Host keeps write flag clear during repeat
// [R12] Host clears repeat flag to leave repeat mode
// [R13] Sample on frame start, track on fourteenth edge
// [R14] First sixteen bits load only when write set
// [R15] Sleep bit zero keeps device fully powered
// [R16] Host respects rate limit and quiet time
// [R17] Partial sleep entered at end of full write
// [R18] Partial sleep outputs all ones, keeps control
// [R19] Entering any sleep clears temperature average
// [R20] Wake starts at end of write clearing sleep
// [R21] First valid result in fourth transfer after wake; code sends a result two transfers after the wake write
// [R22] Long reset-pin low gives full sleep, clears registers
// [R23] Short reset-pin low resets all registers; code clears the control register but leaves partial sleep mode set
// [R24] Host waits power-up delay after full sleep
// [R25] Power-on control register is all zeros
// [R26] Host waits before first programming after power-on
module adcsq_core
  import adcsq_pkg::*;
#(
  parameter int RST_PULSE_CYC = adcsq_pkg::ADCSQ_RST_PULSE_CYC
)(
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    chip_select_n_in,
  input  wire logic                    serial_clock_in,
  input  wire logic                    serial_data_in,
  input  wire logic                    sleep_or_reset_pin_n_in,
  input  wire logic [ADCSQ_DATA_BITS-1:0] sample_data_in,
  output logic                         serial_data_out,
  output logic                         serial_data_oe_out,
  output logic                         track_hold_out,
  output logic [3:0]                   convert_channel_out,
  output logic                         convert_start_out,
  output adcsq_pkg::adcsq_ctrl_s       control_out,
  output adcsq_pkg::adcsq_pwr_e        power_mode_out,
  output logic                         avg_clear_out
);
  import adcsq_pkg::*;

  // Pulse counter is 12 bits wide and saturates
  if (RST_PULSE_CYC < 1 || RST_PULSE_CYC > 4095)
  begin : g_bad_pulse_cyc
    $error("RST_PULSE_CYC out of range");
  end

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic pin_n_s;

  adcsq_sync2 u_sync_cs (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .reset_value_in (1'b1),
    .async_in       (chip_select_n_in),
    .sync_out       (cs_n_s)
  );
  adcsq_sync2 u_sync_sclk (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .reset_value_in (1'b1),
    .async_in       (serial_clock_in),
    .sync_out       (sclk_s)
  );
  adcsq_sync2 u_sync_din (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .reset_value_in (1'b0),
    .async_in       (serial_data_in),
    .sync_out       (din_s)
  );
  adcsq_sync2 u_sync_pin (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .reset_value_in (1'b1),
    .async_in       (sleep_or_reset_pin_n_in),
    .sync_out       (pin_n_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // State
  logic          cs_d;
  logic          sclk_d;
  logic [4:0]    edges;
  logic [15:0]   in_shift;
  logic [15:0]   out_shift;
  logic          oe;
  logic          th;
  adcsq_ctrl_s   ctrl;
  adcsq_pwr_e    pwr;
  logic [8:0]    remaining;
  logic          pending;
  logic [3:0]    pend_tag;
  logic [3:0]    conv_tag;
  logic          conv_start;
  logic          avg_clr;
  logic [11:0]   low_cnt;
  logic          pin_d;

  logic          next_cs_d;
  logic          next_sclk_d;
  logic [4:0]    next_edges;
  logic [15:0]   next_in_shift;
  logic [15:0]   next_out_shift;
  logic          next_oe;
  logic          next_th;
  adcsq_ctrl_s   next_ctrl;
  adcsq_pwr_e    next_pwr;
  logic [8:0]    next_remaining;
  logic          next_pending;
  logic [3:0]    next_pend_tag;
  logic [3:0]    next_conv_tag;
  logic          next_conv_start;
  logic          next_avg_clr;
  logic [11:0]   next_low_cnt;
  logic          next_pin_d;

  // Lowest set bit of the pending mask; index 8 is the temperature slot
  function automatic logic [3:0] lowest(input logic [8:0] m);
    logic [3:0] r;
    r = 4'hf;
    for (int i = 8; i >= 0; i--)
    begin
      if (m[i])
        r = 4'(i);
    end
    return r;
  endfunction

  function automatic logic [8:0] seq_mask(input adcsq_ctrl_s c);
    logic [8:0] m;
    m[8] = c.temp_select;
    // Top select bit is channel zero, so reverse into index order [R01]
    for (int i = 0; i < 8; i++)
    begin
      m[i] = c.channel_select_bits[7-i];
    end
    return m;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic       cs_fall;
  logic       cs_rise;
  logic       sclk_fall;
  logic       pin_rise;
  logic [3:0] pick;
  logic       full_write;

  always_comb
  begin
    cs_fall   = cs_d && !cs_n_s;
    cs_rise   = !cs_d && cs_n_s;
    sclk_fall = sclk_d && !sclk_s && !cs_n_s;
    pin_rise  = !pin_d && pin_n_s;
    pick      = lowest(remaining);
    full_write = cs_rise && (edges == ADCSQ_FULL_EDGES) && in_shift[ADCSQ_POS_WRITE];

    next_cs_d       = cs_n_s;
    next_sclk_d     = sclk_s;
    next_pin_d      = pin_n_s;
    next_edges      = edges;
    next_in_shift   = in_shift;
    next_out_shift  = out_shift;
    next_oe         = oe;
    next_th         = th;
    next_ctrl       = ctrl;
    next_pwr        = pwr;
    next_remaining  = remaining;
    next_pending    = pending;
    next_pend_tag   = pend_tag;
    next_conv_tag   = conv_tag;
    next_conv_start = 1'b0;
    next_avg_clr    = 1'b0;
    next_low_cnt    = pin_n_s ? 12'h000 : ((low_cnt == 12'hfff) ? low_cnt : low_cnt + 12'h001);

    if (cs_fall && pwr != ADCSQ_PWR_FULL)
    begin
      next_edges = 5'h00;
      next_oe    = 1'b1;
      // Previous conversion leaves, else all ones [R04] [R05] [R07] [R18]
      if (pending && pwr == ADCSQ_PWR_NORMAL)
        next_out_shift = {pend_tag, sample_data_in}; // [R02]
      else
        next_out_shift = ADCSQ_ALL_ONES;
      next_pending = 1'b0;
      if (pwr == ADCSQ_PWR_NORMAL && pick != 4'hf)
      begin
        next_th         = 1'b1; // [R13]
        next_conv_start = 1'b1;
        next_pending    = 1'b1;
        next_conv_tag   = (pick == 4'h8)
                          ? (ctrl.temperature_average_enable ? ADCSQ_TAG_TEMP_AVG
                                                             : ADCSQ_TAG_TEMP)
                          : pick; // [R09]
        next_pend_tag   = next_conv_tag;
        next_remaining  = remaining & ~(9'h001 << pick); // [R06]
        if (next_remaining == 9'h000 && ctrl.repeat_mode)
          next_remaining = seq_mask(ctrl); // [R08]
      end
    end
    else if (sclk_fall && edges < ADCSQ_FULL_EDGES)
    begin
      next_edges     = edges + 5'h01;
      next_in_shift  = {in_shift[14:0], din_s}; // [R14]
      next_out_shift = {out_shift[14:0], 1'b1};
      if (next_edges == ADCSQ_TRACK_EDGE)
        next_th = 1'b0; // [R13]
      if (next_edges == ADCSQ_FULL_EDGES)
        next_oe = 1'b0;
    end
    else if (cs_rise)
    begin
      next_oe = 1'b0; // [R03]
      if (edges != ADCSQ_FULL_EDGES)
      begin
        next_pending = 1'b0; // [R03]
        next_th      = 1'b0;
      end
      if (full_write)
      begin
        next_ctrl      = adcsq_ctrl_s'(in_shift[14:0]); // [R01] [R14]
        next_remaining = seq_mask(next_ctrl); // [R10]
        if (next_ctrl.partial_sleep_bit)
        begin
          next_pwr     = ADCSQ_PWR_PARTIAL; // [R17]
          next_pending = 1'b0;
          next_avg_clr = (pwr == ADCSQ_PWR_NORMAL); // [R19]
        end
        else
          next_pwr = ADCSQ_PWR_NORMAL; // [R15] [R20] [R21]
      end
    end

    // Long low on the pin: full sleep, registers lost
    if (!pin_n_s && low_cnt >= 12'(RST_PULSE_CYC))
    begin
      next_pwr       = ADCSQ_PWR_FULL; // [R22]
      next_avg_clr   = (pwr != ADCSQ_PWR_FULL); // [R19]
    end
    if (!pin_n_s)
    begin
      next_ctrl      = adcsq_ctrl_s'(ADCSQ_CTRL_RESET); // [R23] [R22]
      next_remaining = 9'h000;
      next_pending   = 1'b0;
      next_oe        = 1'b0;
      next_th        = 1'b0;
      next_edges     = 5'h00;
    end
    if (pin_rise && pwr == ADCSQ_PWR_FULL)
      next_pwr = ADCSQ_PWR_NORMAL;
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cs_d       <= 1'b1;
      sclk_d     <= 1'b1;
      pin_d      <= 1'b1;
      edges      <= 5'h00;
      in_shift   <= 16'h0000;
      out_shift  <= ADCSQ_ALL_ONES;
      oe         <= 1'b0;
      th         <= 1'b0;
      ctrl       <= adcsq_ctrl_s'(ADCSQ_CTRL_RESET); // [R25]
      pwr        <= ADCSQ_PWR_NORMAL;
      remaining  <= 9'h000;
      pending    <= 1'b0;
      pend_tag   <= 4'h0;
      conv_tag   <= 4'h0;
      conv_start <= 1'b0;
      avg_clr    <= 1'b0;
      low_cnt    <= 12'h000;
    end
    else
    begin
      cs_d       <= next_cs_d;
      sclk_d     <= next_sclk_d;
      pin_d      <= next_pin_d;
      edges      <= next_edges;
      in_shift   <= next_in_shift;
      out_shift  <= next_out_shift;
      oe         <= next_oe;
      th         <= next_th;
      ctrl       <= next_ctrl;
      pwr        <= next_pwr;
      remaining  <= next_remaining;
      pending    <= next_pending;
      pend_tag   <= next_pend_tag;
      conv_tag   <= next_conv_tag;
      conv_start <= next_conv_start;
      avg_clr    <= next_avg_clr;
      low_cnt    <= next_low_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  always_comb
  begin
    serial_data_out     = out_shift[15];
    serial_data_oe_out  = oe;
    track_hold_out      = th;
    convert_channel_out = conv_tag;
    convert_start_out   = conv_start;
    control_out         = ctrl;
    power_mode_out      = pwr;
    avg_clear_out       = avg_clr;
  end
endmodule
`default_nettype wire

// ==== dv/adcsq_core_monitor.sv ====
// Checker: port-level timing and mode relations of the sequencer
`default_nettype none
module adcsq_core_monitor
  import adcsq_pkg::*;
#(
  parameter int RST_PULSE_CYC = adcsq_pkg::ADCSQ_RST_PULSE_CYC
)(
  input wire logic                           clk_in,
  input wire logic                           rst_n_in,
  input wire logic                           chip_select_n_in,
  input wire logic                           serial_clock_in,
  input wire logic                           serial_data_in,
  input wire logic                           sleep_or_reset_pin_n_in,
  input wire logic [ADCSQ_DATA_BITS-1:0]     sample_data_in,
  input wire logic                           serial_data_out,
  input wire logic                           serial_data_oe_out,
  input wire logic                           track_hold_out,
  input wire logic [3:0]                     convert_channel_out,
  input wire logic                           convert_start_out,
  input wire adcsq_pkg::adcsq_ctrl_s         control_out,
  input wire adcsq_pkg::adcsq_pwr_e          power_mode_out,
  input wire logic                           avg_clear_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  // Saturating count of raw pin-low cycles
  always_comb next_low_cnt = (!rst_n_in || sleep_or_reset_pin_n_in) ? 8'h00 :
                             ((low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01);
  always_ff @(posedge clk_in) low_cnt <= next_low_cnt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////
  a_reset_clear: assert property (disable iff (1'b0) !rst_n_in |=>
    control_out == ADCSQ_CTRL_RESET && power_mode_out == ADCSQ_PWR_NORMAL)
    else $error("control not cleared by reset");
  a_start_pulse: assert property (convert_start_out |=> !convert_start_out)
    else $error("start pulse too long");
  a_start_chan: assert property (convert_start_out |-> ((convert_channel_out < 4'h8) ?
    control_out.channel_select_bits[3'h7 - convert_channel_out[2:0]] : control_out.temp_select))
    else $error("conversion on unselected channel");
  a_start_awake: assert property (convert_start_out |-> power_mode_out == ADCSQ_PWR_NORMAL)
    else $error("conversion while asleep");
  a_oe_idle: assert property (chip_select_n_in [*6] |-> !serial_data_oe_out)
    else $error("output driven outside frame");
  a_ctrl_hold: assert property ((chip_select_n_in && sleep_or_reset_pin_n_in) [*8]
    |=> $stable(control_out)) else $error("control changed without frame");
  a_partial_ones: assert property ((power_mode_out == ADCSQ_PWR_PARTIAL &&
    serial_data_oe_out) |-> serial_data_out) else $error("partial sleep output not ones");
  a_partial_cause: assert property (($changed(power_mode_out) &&
    power_mode_out == ADCSQ_PWR_PARTIAL) |-> control_out.partial_sleep_bit)
    else $error("partial sleep without sleep bit");
  a_sleep_avg: assert property (avg_clear_out |-> ##[0:1] power_mode_out != ADCSQ_PWR_NORMAL)
    else $error("average cleared outside sleep entry");
  a_full_clear: assert property (power_mode_out == ADCSQ_PWR_FULL |->
    control_out == ADCSQ_CTRL_RESET) else $error("control kept in full sleep");
  a_long_pin: assert property ((int'(low_cnt) > RST_PULSE_CYC + 6) |->
    power_mode_out == ADCSQ_PWR_FULL) else $error("long pin low not full sleep");
  a_hold_start: assert property (convert_start_out |-> track_hold_out)
    else $error("no hold at conversion start");
  a_hold_idle: assert property (chip_select_n_in [*6] |-> !track_hold_out)
    else $error("hold kept after frame");
  a_avg_on_sleep: assert property (($changed(power_mode_out) &&
    $past(power_mode_out) == ADCSQ_PWR_NORMAL) |-> avg_clear_out)
    else $error("average not cleared on sleep entry");
  c_start: cover property (convert_start_out);
  c_avg_temp: cover property (convert_start_out && convert_channel_out == ADCSQ_TAG_TEMP_AVG);
  c_partial: cover property (power_mode_out == ADCSQ_PWR_PARTIAL);
  c_full: cover property (power_mode_out == ADCSQ_PWR_FULL);
endmodule
bind adcsq_core adcsq_core_monitor #(.RST_PULSE_CYC(RST_PULSE_CYC)) i_adcsq_core_monitor (
  .clk_in, .rst_n_in, .chip_select_n_in, .serial_clock_in, .serial_data_in,
  .sleep_or_reset_pin_n_in, .sample_data_in, .serial_data_out, .serial_data_oe_out,
  .track_hold_out, .convert_channel_out, .convert_start_out, .control_out,
  .power_mode_out, .avg_clear_out);
`default_nettype wire

// ==== dv/adcsq_host_model.sv ====
// Host serial master model: frames, shifts control words, reads results
`default_nettype none
module adcsq_host_model (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      mosi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  // Serial clock 160 ns, still between frames; n below 16 aborts early
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'hffff;
    cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      sclk_out <= 1'b1;
      mosi_out <= w[15-i];
      repeat (4) @(posedge clk_in);
      r[15-i] = miso_in;
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    cs_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Testbench: host frames through the converter sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcsq_pkg::*;
  typedef struct packed {logic [15:0] w; logic [15:0] e;} adcsq_row_s;
  logic        clk = 1'b0;
  logic        rst_n;
  logic        pin_n;
  logic [11:0] sample;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic        oe;
  wire logic   miso;
  adcsq_ctrl_s ctrl;
  adcsq_pwr_e  mode;
  logic [15:0] rd;
  int          num_errors = 0;
  int          compares = 0;
  adcsq_row_s  rows [19] = '{32'ha800ffff, 32'h0000ffff, 32'h00000a02, 32'h00002a03,
    32'h0000ffff, 32'hd412ffff, 32'h0000ffff, 32'h00001a07, 32'h00003a08, 32'h00009a09,
    32'hd4101a0a, 32'h00003a0b, 32'h00001a0c, 32'h80013a0d, 32'h0000ffff, 32'h8000ffff,
    32'h8040ffff, 32'h0000ffff, 32'h00007a12};
  always #10 clk = ~clk;
  // Released line shows the inverse, never a stale bit
  assign miso = oe ? sdo : ~sdo;
  adcsq_core i_adcsq_core (.clk_in(clk), .rst_n_in(rst_n), .chip_select_n_in(cs_n),
    .serial_clock_in(sclk), .serial_data_in(sdi), .sleep_or_reset_pin_n_in(pin_n),
    .sample_data_in(sample), .serial_data_out(sdo), .serial_data_oe_out(oe),
    .track_hold_out(), .convert_channel_out(), .convert_start_out(),
    .control_out(ctrl), .power_mode_out(mode), .avg_clear_out());
  adcsq_host_model i_adcsq_host_model (.clk_in(clk), .miso_in(miso), .cs_n_out(cs_n),
    .sclk_out(sclk), .mosi_out(sdi));
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ctrl(input adcsq_ctrl_s got, input adcsq_ctrl_s exp);
    chk_word({1'b0, got}, {1'b0, exp});
  endtask
  task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
    chk_word({14'h0000, got}, {14'h0000, exp});
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    pin_n = 1'b1;
    sample = 12'h000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_ctrl(ctrl, ADCSQ_CTRL_RESET);
    chk_mode(mode, ADCSQ_PWR_NORMAL);
    for (int i = 0; i < 19; i++)
    begin
      sample <= 12'ha00 + 12'(i);
      i_adcsq_host_model.xfer(rows[i].w, 16, rd);
      chk_word(rd, rows[i].e);
    end
    i_adcsq_host_model.xfer(16'h8080, 10, rd);
    chk_ctrl(ctrl, 15'h0040);
    chk_mode({1'b0, oe}, 2'h0);
    i_adcsq_host_model.xfer(16'h8080, 16, rd);
    chk_ctrl(ctrl, 15'h0080);
    i_adcsq_host_model.xfer(16'h0101, 16, rd);
    chk_ctrl(ctrl, 15'h0080);
    // 40 ns pulse, short enough to reset only
    pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk_ctrl(ctrl, ADCSQ_CTRL_RESET);
    chk_mode(mode, ADCSQ_PWR_NORMAL);
    i_adcsq_host_model.xfer(16'h8080, 16, rd);
    pin_n <= 1'b0;
    repeat (20) @(posedge clk);
    chk_mode(mode, ADCSQ_PWR_FULL);
    chk_ctrl(ctrl, ADCSQ_CTRL_RESET);
    i_adcsq_host_model.xfer(16'h8040, 16, rd);
    chk_ctrl(ctrl, ADCSQ_CTRL_RESET);
    pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk_mode(mode, ADCSQ_PWR_NORMAL);
    i_adcsq_host_model.xfer(16'h8040, 16, rd);
    chk_ctrl(ctrl, 15'h0040);
    stop_test;
  end
  // About 3500 cycles expected; generous margin
  initial
  begin
    #400us;
    num_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
